// ==== design/avc_mode_volume.sv ====
`timescale 1ns/1ps
module avc_mode_volume
  import avc_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire logic                    formatSelectHi,
  input  wire logic                    formatSelectLo,
  input  wire logic                    controlStyleSelect,
  input  wire logic                    serialDataOrAttenPin,
  input  wire logic                    serialClockOrSpeedPin,
  input  wire logic                    latchOrMutePin,
  input  wire logic                    deemphOrStylePin,
  input  wire logic                    wordSelect,
  input  wire logic [AVC_SAMPLE_W-1:0] leftSample,
  input  wire logic [AVC_SAMPLE_W-1:0] rightSample,
  input  wire logic                    sampleValid,
  output avc_format_t                  audioFormat,
  output logic                         doubleSpeed,
  output logic [8:0]                   sysClkRatio,
  output logic                         microStyle,
  output logic                         deemphasisEnable,
  output logic [AVC_FADE_W-1:0]        fadeCount,
  output logic [AVC_MODE_W-1:0]        modeControl,
  output logic [AVC_SAMPLE_W-1:0]      leftOut,
  output logic [AVC_SAMPLE_W-1:0]      rightOut,
  output logic                         outValid
);

  function automatic logic [AVC_SAMPLE_W-1:0] scaleSample(
    input logic [AVC_SAMPLE_W-1:0] s,
    input logic [AVC_FADE_W-1:0]   c
  );
    logic signed [27:0] p;
    logic signed [27:0] q;
    p = 28'sh000_0000;
    q = 28'sh000_0000;
    p = $signed(s) * $signed({1'b0, c});
    q = p / $signed(AVC_FADE_DIV);
    return q[AVC_SAMPLE_W-1:0];
  endfunction

  function automatic logic [AVC_FADE_W-1:0] stepFade(
    input logic [AVC_FADE_W-1:0] v,
    input logic                  up,
    input logic                  down
  );
    logic [AVC_FADE_W-1:0] r;
    r = v;
    if (up && !down && v < AVC_FADE_FULL) begin
      r = v + 7'h01;
    end else if (down && !up && v > AVC_FADE_MUTE) begin
      r = v - 7'h01;
    end
    return r;
  endfunction

  function automatic logic riseOf(
    input logic cur,
    input logic prev
  );
    return cur && !prev;
  endfunction

  // link domain: serial shift register on the host shift clock
  // a long frame leaves only its last eight bits
  logic [AVC_MODE_W-1:0] shiftWord_q;

  always_ff @(posedge serialClockOrSpeedPin or negedge rstn) begin
    if (!rstn) begin
      shiftWord_q <= 8'h00;
    end else begin
      shiftWord_q <= {shiftWord_q[AVC_MODE_W-2:0], serialDataOrAttenPin};
    end
  end

  // two-flop synchronisers for every pin level
  logic [7:0] pinMeta_q;
  logic [7:0] pinSync_q;
  logic [7:0] pinRaw;

  assign pinRaw = {wordSelect, formatSelectHi, formatSelectLo, controlStyleSelect,
                   serialDataOrAttenPin, serialClockOrSpeedPin, latchOrMutePin,
                   deemphOrStylePin};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      // stages reset to the pins' idle levels, so no false strobe edge
      pinMeta_q <= AVC_PIN_IDLE;
      pinSync_q <= AVC_PIN_IDLE;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  logic wordSelectSync;
  logic fmtHiSync;
  logic fmtLoSync;
  logic styleSelSync;
  logic pin0Sync;
  logic pin1Sync;
  logic pin2Sync;
  logic pin3Sync;

  assign wordSelectSync = pinSync_q[7];
  assign fmtHiSync = pinSync_q[6];
  assign fmtLoSync = pinSync_q[5];
  assign styleSelSync = pinSync_q[4];
  assign pin0Sync = pinSync_q[3];
  assign pin1Sync = pinSync_q[2];
  assign pin2Sync = pinSync_q[1];
  assign pin3Sync = pinSync_q[0];

  // control style decode
  logic styleMicro;
  logic stylePins;

  assign styleMicro = styleSelSync && !pin3Sync;
  assign stylePins = !styleSelSync;

  // edge detection on synchronised strobe and word select
  logic latchPrev_q;
  logic wordPrev_q;
  logic latchRise;
  logic sampleTick;

  // strobe idles high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      latchPrev_q <= 1'b1;
    end else begin
      latchPrev_q <= pin2Sync;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wordPrev_q <= 1'b0;
    end else begin
      wordPrev_q <= wordSelectSync;
    end
  end

  assign latchRise = riseOf(pin2Sync, latchPrev_q);
  assign sampleTick = riseOf(wordSelectSync, wordPrev_q);

  // shift clock stands high during a valid strobe, so the word is static here
  logic execCmd;

  assign execCmd = styleMicro && latchRise && pin1Sync;

  // mode control register
  logic [AVC_MODE_W-1:0] mode_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= AVC_MODE_RESET;
    end else if (execCmd) begin
      mode_q <= shiftWord_q;
    end
  end

  // requested static functions from either style
  avc_ctrl_t ctrlReq;

  always_comb begin
    ctrlReq = '{attenuate12dbN: 1'b1, doubleSpeedN: 1'b1, muteRequestN: 1'b1,
                deemphasisEnable: 1'b0};
    if (stylePins) begin
      ctrlReq.attenuate12dbN = pin0Sync;
      ctrlReq.doubleSpeedN = pin1Sync;
      ctrlReq.muteRequestN = pin2Sync;
      ctrlReq.deemphasisEnable = pin3Sync;
    end else begin
      ctrlReq.attenuate12dbN = mode_q[AVC_BIT_ATTEN_N];
      ctrlReq.doubleSpeedN = mode_q[AVC_BIT_DOUBLE_N];
      ctrlReq.muteRequestN = mode_q[AVC_BIT_MUTE_N];
      ctrlReq.deemphasisEnable = mode_q[AVC_BIT_DEEMPH];
    end
  end

  // fade counter target
  logic [AVC_FADE_W-1:0] target_q;
  logic [AVC_FADE_W-1:0] fade_q;
  logic [AVC_FADE_W-1:0] cmdTarget;
  logic [AVC_MODE_W-1:0] cmdWord;

  assign cmdWord = shiftWord_q;

  // steps move the target; the counter follows at sample ticks
  always_comb begin
    cmdTarget = stepFade(target_q, cmdWord[AVC_BIT_STEP_UP],
                         cmdWord[AVC_BIT_STEP_DOWN]);
    if (!cmdWord[AVC_BIT_MUTE_N]) begin
      cmdTarget = AVC_FADE_MUTE;
    end else if (cmdWord[AVC_BIT_FULL]) begin
      cmdTarget = AVC_FADE_FULL;
    end else if (!cmdWord[AVC_BIT_ATTEN_N] && fade_q > AVC_FADE_ATTEN) begin
      cmdTarget = AVC_FADE_ATTEN;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      target_q <= AVC_FADE_FULL;
    end else if (stylePins) begin
      if (!ctrlReq.muteRequestN) begin
        target_q <= AVC_FADE_MUTE;
      end else if (!ctrlReq.attenuate12dbN) begin
        target_q <= AVC_FADE_ATTEN;
      end else begin
        target_q <= AVC_FADE_FULL;
      end
    end else if (execCmd) begin
      target_q <= cmdTarget;
    end
  end

  // counter follows target one step per sample
  // starts from silence after reset and ramps up
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fade_q <= AVC_FADE_MUTE;
    end else if (sampleTick) begin
      if (fade_q < target_q) begin
        fade_q <= fade_q + 7'h01;
      end else if (fade_q > target_q) begin
        fade_q <= fade_q - 7'h01;
      end
    end
  end

  // de-emphasis aligned to word boundaries
  logic deemph_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      deemph_q <= 1'b0;
    end else if (sampleTick) begin
      deemph_q <= ctrlReq.deemphasisEnable;
    end
  end

  // speed and expected clock ratio
  logic dbl_q;
  logic dbl_d;

  always_comb begin
    dbl_d = dbl_q;
    if (styleMicro || stylePins) begin
      dbl_d = !ctrlReq.doubleSpeedN;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dbl_q <= 1'b0;
    end else begin
      dbl_q <= dbl_d;
    end
  end

  logic [8:0] ratio_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ratio_q <= AVC_RATIO_NORMAL;
    end else begin
      // next speed, so ratio and speed move together
      ratio_q <= dbl_d ? AVC_RATIO_DOUBLE : AVC_RATIO_NORMAL;
    end
  end

  // input format decode
  avc_format_t format_q;
  avc_format_t formatD;

  always_comb begin
    formatD.mode = avc_format_e_t'({fmtHiSync, fmtLoSync});
    case (formatD.mode)
      AVC_FMT_I2S: begin
        formatD.wordLen = AVC_WLEN_20;
      end
      AVC_FMT_RJ16: begin
        formatD.wordLen = AVC_WLEN_16;
      end
      AVC_FMT_RJ18: begin
        formatD.wordLen = AVC_WLEN_18;
      end
      AVC_FMT_RJ20: begin
        formatD.wordLen = AVC_WLEN_20;
      end
      default: begin
        formatD.wordLen = AVC_WLEN_20;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      format_q <= '{mode: AVC_FMT_I2S, wordLen: AVC_WLEN_20};
    end else begin
      format_q <= formatD;
    end
  end

  // both channels scaled by the fade counter
  logic [AVC_SAMPLE_W-1:0] left_q;
  logic [AVC_SAMPLE_W-1:0] right_q;
  logic                    valid_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      left_q <= 20'h0_0000;
      right_q <= 20'h0_0000;
    end else if (sampleValid) begin
      left_q <= scaleSample(leftSample, fade_q);
      right_q <= scaleSample(rightSample, fade_q);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= sampleValid;
    end
  end

  logic micro_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      micro_q <= 1'b0;
    end else begin
      micro_q <= styleMicro;
    end
  end

  assign audioFormat = format_q;
  assign doubleSpeed = dbl_q;
  assign sysClkRatio = ratio_q;
  assign microStyle = micro_q;
  assign deemphasisEnable = deemph_q;
  assign fadeCount = fade_q;
  assign modeControl = mode_q;
  assign leftOut = left_q;
  assign rightOut = right_q;
  assign outValid = valid_q;

endmodule

// ==== design/avc_pkg.sv ====
package avc_pkg;

  localparam int AVC_FADE_W = 7;
  localparam logic [6:0] AVC_FADE_FULL = 7'h78;
  localparam logic [6:0] AVC_FADE_ATTEN = 7'h1E;
  localparam logic [6:0] AVC_FADE_MUTE = 7'h00;
  localparam logic [27:0] AVC_FADE_DIV = 28'h000_0078;

  localparam int AVC_MODE_W = 8;
  localparam int AVC_BIT_ATTEN_N = 7;
  localparam int AVC_BIT_DOUBLE_N = 6;
  localparam int AVC_BIT_MUTE_N = 5;
  localparam int AVC_BIT_DEEMPH = 4;
  localparam int AVC_BIT_FULL = 3;
  localparam int AVC_BIT_STEP_UP = 2;
  localparam int AVC_BIT_STEP_DOWN = 1;
  localparam logic [7:0] AVC_MODE_RESET = 8'hE0;
  localparam logic [7:0] AVC_PIN_IDLE = 8'h0E;

  localparam logic [8:0] AVC_RATIO_NORMAL = 9'h100;
  localparam logic [8:0] AVC_RATIO_DOUBLE = 9'h080;

  localparam logic [4:0] AVC_WLEN_16 = 5'h10;
  localparam logic [4:0] AVC_WLEN_18 = 5'h12;
  localparam logic [4:0] AVC_WLEN_20 = 5'h14;

  localparam int AVC_SAMPLE_W = 20;

  typedef enum logic [1:0] {
    AVC_FMT_I2S   = 2'b00,
    AVC_FMT_RJ16  = 2'b01,
    AVC_FMT_RJ18  = 2'b10,
    AVC_FMT_RJ20  = 2'b11
  } avc_format_e_t;

  typedef struct packed {
    avc_format_e_t mode;
    logic [4:0]    wordLen;
  } avc_format_t;

  typedef struct packed {
    logic attenuate12dbN;
    logic doubleSpeedN;
    logic muteRequestN;
    logic deemphasisEnable;
  } avc_ctrl_t;

endpackage

// ==== verif/avc_host_model.sv ====
`timescale 1ns/1ps
module avc_host_model (
  output logic shiftData,
  output logic shiftClk,
  output logic latch
);
  initial begin
    shiftData = 1'b0;
    shiftClk  = 1'b1;
    latch     = 1'b1;
  end
  // msb first; clock parks high outside frames
  task automatic send(input logic [8:0] w, input int n, input logic clkHi);
    latch = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      shiftClk  = 1'b0;
      shiftData = w[i];
      #32;
      shiftClk = 1'b1;
      #32;
    end
    shiftData = ~w[0];
    shiftClk  = clkHi;
    #200;
    latch = 1'b1;
    #200;
    shiftClk = 1'b1;
    #200;
  endtask
  task automatic strobe();
    latch = 1'b0;
    #200;
    latch = 1'b1;
    #200;
  endtask
endmodule

// ==== verif/avc_mode_volume_sva.sv ====
`timescale 1ns/1ps
module avc_mode_volume_sva
  import avc_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    rstn,
  input wire logic                    controlStyleSelect,
  input wire logic                    deemphOrStylePin,
  input wire logic                    wordSelect,
  input wire logic [AVC_SAMPLE_W-1:0] leftSample,
  input wire logic                    sampleValid,
  input avc_format_t                  audioFormat,
  input wire logic                    doubleSpeed,
  input wire logic [8:0]              sysClkRatio,
  input wire logic                    microStyle,
  input wire logic                    deemphasisEnable,
  input wire logic [AVC_FADE_W-1:0]   fadeCount,
  input wire logic [AVC_SAMPLE_W-1:0] leftOut,
  input wire logic                    outValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic       wsPrev_q;
  logic [3:0] wsAge_q;
  // cycles since the last word select rise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wsPrev_q <= 1'b0;
      wsAge_q  <= 4'hF;
    end else begin
      wsPrev_q <= wordSelect;
      wsAge_q  <= (wordSelect && !wsPrev_q) ? 4'h0 : (wsAge_q == 4'hF ? 4'hF : wsAge_q + 4'h1);
    end
  end
  fade_range_a: assert property (fadeCount <= 7'h78) else $error("fade over max");
  fade_step_a: assert property ($changed(fadeCount) |-> fadeCount == $past(fadeCount) + 7'h01
    || fadeCount == $past(fadeCount) - 7'h01) else $error("fade jump");
  fade_sync_a: assert property ($changed(fadeCount) |-> wsAge_q <= 4'h5) else $error("fade off tick");
  deemph_sync_a: assert property ($changed(deemphasisEnable) |-> wsAge_q <= 4'h5)
    else $error("deemph off tick");
  speed_ratio_a: assert property (sysClkRatio == (doubleSpeed ? 9'h080 : 9'h100))
    else $error("bad ratio");
  format_len_a: assert property (audioFormat.wordLen == (audioFormat.mode == AVC_FMT_RJ16 ? 5'h10
    : audioFormat.mode == AVC_FMT_RJ18 ? 5'h12 : 5'h14)) else $error("bad word length");
  micro_style_a: assert property ((controlStyleSelect && !deemphOrStylePin) [*5] |-> microStyle)
    else $error("no micro style");
  pin_style_a: assert property ((!controlStyleSelect) [*5] |-> !microStyle) else $error("no pin style");
  out_full_a: assert property (sampleValid && fadeCount == 7'h78 |=> outValid
    && leftOut == $past(leftSample)) else $error("full scale out wrong");
  out_mute_a: assert property (sampleValid && fadeCount == 7'h00 |=> leftOut == 20'h0_0000)
    else $error("mute out wrong");
endmodule
bind avc_mode_volume avc_mode_volume_sva avc_mode_volume_sva_i (.mclk, .rstn, .controlStyleSelect,
  .deemphOrStylePin, .wordSelect, .leftSample, .sampleValid, .audioFormat, .doubleSpeed,
  .sysClkRatio, .microStyle, .deemphasisEnable, .fadeCount, .leftOut, .outValid);

// ==== verif/test_avc_mode_volume.sv ====
`timescale 1ns/1ps
module test_avc_mode_volume
  import avc_pkg::*;
;
  logic mclk = 1'b0, rstn = 1'b0, fsHi = 1'b0, fsLo = 1'b0, style = 1'b0, ws = 1'b0, sv = 1'b0;
  logic p0 = 1'b1, p1 = 1'b1, p2 = 1'b1, p3 = 1'b0, hD, hC, hL;
  logic [19:0] ls = 20'h0_0000, rs = 20'h0_0000, lo, ro;
  logic [8:0] ratio;
  logic [7:0] mode;
  logic [6:0] fc;
  logic ds, de, ov, ms;
  avc_format_t fmt;
  int miscompares = 0, checks_done = 0, cycles = 0;
  avc_host_model avc_host_model_i (.shiftData(hD), .shiftClk(hC), .latch(hL));
  avc_mode_volume avc_mode_volume_i (.mclk(mclk), .rstn(rstn), .formatSelectHi(fsHi),
    .formatSelectLo(fsLo), .controlStyleSelect(style), .serialDataOrAttenPin(style ? hD : p0),
    .serialClockOrSpeedPin(style ? hC : p1), .latchOrMutePin(style ? hL : p2),
    .deemphOrStylePin(p3), .wordSelect(ws), .leftSample(ls), .rightSample(rs),
    .sampleValid(sv), .audioFormat(fmt), .doubleSpeed(ds), .sysClkRatio(ratio),
    .microStyle(ms), .deemphasisEnable(de), .fadeCount(fc), .modeControl(mode),
    .leftOut(lo), .rightOut(ro), .outValid(ov));
  initial forever #20 mclk = ~mclk;
  initial forever begin
    repeat (8) @(negedge mclk);
    ws = ~ws;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic fade(input logic [6:0] e);
    int n;
    n = 0;
    while (fc !== e && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(fc), 32'(e));
  endtask
  task automatic smp(input logic [19:0] s, input logic [19:0] el);
    @(negedge mclk);
    ls = s;
    rs = -s;
    sv = 1'b1;
    @(negedge mclk);
    sv = 1'b0;
    chk({ov, 11'h000, lo}, {1'b1, 11'h000, el});
    chk(32'(ro), 32'(20'(-el)));
  endtask
  task automatic t_format();
    logic [4:0] len [4];
    len = '{5'h14, 5'h10, 5'h12, 5'h14};
    for (int i = 0; i < 4; i++) begin
      {fsHi, fsLo} = 2'(i);
      repeat (5) @(negedge mclk);
      chk({fmt.mode, fmt.wordLen}, {2'(i), len[i]});
    end
  endtask
  task automatic t_pins();
    fade(7'h78);
    p0 = 1'b0;
    fade(7'h1E);
    smp(20'h0_1000, 20'h0_0400);
    p2 = 1'b0;
    fade(7'h00);
    p1 = 1'b0;
    p3 = 1'b1;
    repeat (40) @(negedge mclk);
    chk({ds, de, ms, ratio}, {3'b110, 9'h080});
  endtask
  task automatic t_micro();
    p1 = 1'b1;
    p2 = 1'b1;
    repeat (4) @(negedge mclk);
    p3 = 1'b0;
    style = 1'b1;
    repeat (6) @(negedge mclk);
    chk(32'(mode), 32'h0000_00E0);
    avc_host_model_i.send(9'h1E8, 9, 1'b1);
    chk(32'(mode), 32'h0000_00E8);
    fade(7'h78);
    chk({ds, de, ms}, 3'b001);
    smp(20'h1_2345, 20'h1_2345);
    avc_host_model_i.send(9'h0C0, 8, 1'b0);
    chk(32'(mode), 32'h0000_00E8);
    avc_host_model_i.send(9'h0C0, 8, 1'b1);
    fade(7'h00);
    smp(20'h0_1234, 20'h0_0000);
    avc_host_model_i.send(9'h0E4, 8, 1'b1);
    fade(7'h01);
    repeat (15520) @(negedge mclk);
    avc_host_model_i.strobe();
    fade(7'h02);
    avc_host_model_i.send(9'h060, 8, 1'b1);
    repeat (60) @(negedge mclk);
    chk(32'(fc), 32'h0000_0002);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    chk({mode, 7'h00, ratio, 1'b0, fc}, {8'hE0, 7'h00, 9'h100, 1'b0, 7'h00});
    repeat (4) @(negedge mclk);
    t_format();
    t_pins();
    t_micro();
    end_of_test();
  end
endmodule
